/* File: core/psc_pkg.sv */
package psc_pkg;

    typedef enum logic [2:0] {
        PSC_C0,
        PSC_C1,
        PSC_C1E,
        PSC_C3,
        PSC_C6,
        PSC_C7
    } psc_cstate_t;

    typedef enum logic [1:0] {
        PSC_MEM_UP,
        PSC_MEM_PRECHARGE_PD,
        PSC_MEM_ACTIVE_PD,
        PSC_MEM_SELF_REFRESH
    } psc_mem_mode_t;

    typedef enum logic [1:0] {
        PSC_LINK_L0,
        PSC_LINK_L0S,
        PSC_LINK_L1,
        PSC_LINK_L3
    } psc_link_t;

    typedef enum logic [2:0] {
        PSC_SYS_S0,
        PSC_SYS_S3,
        PSC_SYS_S4,
        PSC_SYS_S5,
        PSC_SYS_G3
    } psc_sys_t;

    // Per-core action set driven to the core power hardware
    typedef struct packed {
        logic executing;
        logic halted;
        logic min_op_point;
        logic cache_flush;
        logic clock_gated;
        logic state_save;
        logic voltage_off;
    } psc_core_ctl_t;

    // Value after reset: cores run with no saving action applied
    localparam psc_core_ctl_t PSC_CTL_RESET =
        '{executing: 1'b1, default: 1'b0};

    // Latency counts in cycles, deeper states no shorter; C6 and C7 are equal
    localparam logic [7:0] PSC_LAT_C1  = 8'h01;
    localparam logic [7:0] PSC_LAT_C1E = 8'h02;
    localparam logic [7:0] PSC_LAT_C3  = 8'h04;
    localparam logic [7:0] PSC_LAT_C6  = 8'h08;
    localparam logic [7:0] PSC_LAT_C7  = 8'h08;
    localparam int         PSC_NUM_CORES   = 4;
    localparam int         PSC_NUM_THREADS = 2;
    localparam int         PSC_LLC_WAYS    = 16;

endpackage

/* File: core/psc_core_fsm.sv */
`timescale 1ns/100ps
// One core: walks the entry sequence for the resolved idle level
module psc_core_fsm (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire psc_pkg::psc_cstate_t i_target,
    input  wire logic                 i_flush_done,
    input  wire logic                 i_save_done,
    output psc_pkg::psc_cstate_t      o_state,
    output psc_pkg::psc_core_ctl_t    o_ctl
);
    typedef enum logic [2:0] {
        PSC_ST_RUN,
        PSC_ST_ENTER,
        PSC_ST_FLUSH,
        PSC_ST_SAVE,
        PSC_ST_IDLE,
        PSC_ST_EXIT
    } psc_fsm_t;

    psc_fsm_t             st_q;
    psc_pkg::psc_cstate_t cur_q;
    logic [7:0]           lat_q;

    function automatic logic [7:0] lat_of(psc_pkg::psc_cstate_t s);
        unique case (s)
            psc_pkg::PSC_C0:  lat_of = 8'h00;
            psc_pkg::PSC_C1:  lat_of = psc_pkg::PSC_LAT_C1;
            psc_pkg::PSC_C1E: lat_of = psc_pkg::PSC_LAT_C1E;
            psc_pkg::PSC_C3:  lat_of = psc_pkg::PSC_LAT_C3;
            psc_pkg::PSC_C6:  lat_of = psc_pkg::PSC_LAT_C6;
            default:          lat_of = psc_pkg::PSC_LAT_C7;
        endcase
    endfunction

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_q  <= PSC_ST_RUN;
            cur_q <= psc_pkg::PSC_C0;
            lat_q <= 8'h00;
        end else begin
            unique case (st_q)
                PSC_ST_RUN: if (i_target != psc_pkg::PSC_C0) begin
                    cur_q <= i_target;
                    lat_q <= lat_of(i_target);
                    st_q  <= PSC_ST_ENTER;
                end
                PSC_ST_ENTER: if (lat_q <= 8'h01) begin
                    if (cur_q >= psc_pkg::PSC_C6)
                        st_q <= PSC_ST_SAVE;
                    else if (cur_q == psc_pkg::PSC_C3)
                        st_q <= PSC_ST_FLUSH;
                    else
                        st_q <= PSC_ST_IDLE;
                end else begin
                    lat_q <= lat_q - 8'h01;
                end
                PSC_ST_FLUSH: if (i_flush_done) st_q <= PSC_ST_IDLE;
                PSC_ST_SAVE:  if (i_save_done)  st_q <= PSC_ST_IDLE;
                PSC_ST_IDLE: if (i_target != cur_q) begin
                    // Any change returns through active first
                    lat_q <= lat_of(cur_q);
                    st_q  <= PSC_ST_EXIT;
                end
                PSC_ST_EXIT: if (lat_q <= 8'h01) begin
                    cur_q <= psc_pkg::PSC_C0;
                    st_q  <= PSC_ST_RUN;
                end else begin
                    lat_q <= lat_q - 8'h01;
                end
                default: st_q <= PSC_ST_RUN;
            endcase
        end
    end

    always_comb begin
        o_state = (st_q == PSC_ST_RUN) ? psc_pkg::PSC_C0 : cur_q;
        o_ctl   = '0;
        o_ctl.executing = (st_q == PSC_ST_RUN);
        if (st_q != PSC_ST_RUN) begin
            o_ctl.halted       = 1'b1;
            o_ctl.min_op_point = (cur_q != psc_pkg::PSC_C1);
        end
        if (cur_q == psc_pkg::PSC_C3 && st_q == PSC_ST_FLUSH)
            o_ctl.cache_flush = 1'b1;
        if (cur_q >= psc_pkg::PSC_C3 && st_q == PSC_ST_IDLE)
            o_ctl.clock_gated = 1'b1;
        if (cur_q >= psc_pkg::PSC_C6 && st_q == PSC_ST_SAVE)
            o_ctl.state_save = 1'b1;
        if (cur_q >= psc_pkg::PSC_C6 && st_q == PSC_ST_IDLE)
            o_ctl.voltage_off = 1'b1;
    end
endmodule

/* File: core/psc_coordinator.sv */
`timescale 1ns/100ps
module psc_coordinator #(
    parameter int NUM_CORES   = psc_pkg::PSC_NUM_CORES,
    parameter int NUM_THREADS = psc_pkg::PSC_NUM_THREADS,
    parameter int LLC_WAYS    = psc_pkg::PSC_LLC_WAYS
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    input  wire psc_pkg::psc_cstate_t   i_thread_req [NUM_CORES][NUM_THREADS],
    input  wire logic [NUM_CORES-1:0]   i_flush_done,
    input  wire logic [NUM_CORES-1:0]   i_save_done,
    input  wire logic                   i_way_flushed,
    input  wire psc_pkg::psc_mem_mode_t i_mem_req,
    input  wire logic                   i_banks_open,
    input  wire psc_pkg::psc_link_t     i_pcie_req,
    input  wire psc_pkg::psc_link_t     i_chipset_link_req,
    input  wire psc_pkg::psc_sys_t      i_sys_state,
    input  wire logic                   i_gfx_d3,
    output psc_pkg::psc_core_ctl_t      o_core_ctl [NUM_CORES],
    output psc_pkg::psc_cstate_t        o_core_state [NUM_CORES],
    output logic                        o_llc_flush,
    output logic [$clog2(LLC_WAYS)-1:0] o_llc_way,
    output logic                        o_llc_power_off,
    output logic                        o_system_agent_off,
    output logic                        o_dram_cke,
    output psc_pkg::psc_mem_mode_t      o_mem_mode,
    output psc_pkg::psc_link_t          o_pcie_state,
    output psc_pkg::psc_link_t          o_chipset_link_state,
    output logic                        o_display_on,
    output logic                        o_gfx_power_on,
    output logic                        o_package_power_on,
    output logic                        o_rtc_clock_on
);
    localparam int WW = $clog2(LLC_WAYS);

    // A single way would leave the way counter with no bits
    if (NUM_CORES < 1 || NUM_THREADS < 1 ||
        LLC_WAYS < 2) begin : g_bad_cfg
        $error("psc_coordinator: unsupported parameters");
    end

    psc_pkg::psc_cstate_t   target     [NUM_CORES];
    psc_pkg::psc_cstate_t   fsm_state  [NUM_CORES];
    psc_pkg::psc_core_ctl_t fsm_ctl    [NUM_CORES];
    logic [WW-1:0]          way_q;
    logic                   llc_empty_q;
    logic                   llc_flush_q;
    logic                   all_c7;
    logic                   all_c1;
    logic                   in_s0;
    logic                   gfx_asleep;

    // Lower code is shallower, so the minimum is the shallowest request
    function automatic psc_pkg::psc_cstate_t resolve(
        input psc_pkg::psc_cstate_t a, input psc_pkg::psc_cstate_t b);
        resolve = (a < b) ? a : b;
    endfunction

    // Per-core resolution; C1E only when every core requests C1 or deeper
    always_comb begin
        all_c7 = 1'b1;
        all_c1 = 1'b1;
        for (int c = 0; c < NUM_CORES; c++) begin
            target[c] = i_thread_req[c][0];
            for (int t = 1; t < NUM_THREADS; t++)
                target[c] = resolve(target[c], i_thread_req[c][t]);
            if (target[c] != psc_pkg::PSC_C7) all_c7 = 1'b0;
            if (target[c] == psc_pkg::PSC_C0) all_c1 = 1'b0;
        end
        for (int c = 0; c < NUM_CORES; c++) begin
            if (target[c] == psc_pkg::PSC_C1E && !all_c1)
                target[c] = psc_pkg::PSC_C1;
        end
    end

    for (genvar g = 0; g < NUM_CORES; g++) begin : g_core
        psc_core_fsm u_core (
            .i_clk        (i_clk),
            .i_rst_n      (i_rst_n),
            .i_target     (target[g]),
            .i_flush_done (i_flush_done[g]),
            .i_save_done  (i_save_done[g]),
            .o_state      (fsm_state[g]),
            .o_ctl        (fsm_ctl[g])
        );
    end

    // Reset shows cores running, as the sequencers do in their idle-free state
    always_ff @(posedge i_clk) begin
        for (int c = 0; c < NUM_CORES; c++) begin
            if (!i_rst_n) begin
                o_core_ctl[c]   <= psc_pkg::PSC_CTL_RESET;
                o_core_state[c] <= psc_pkg::PSC_C0;
            end else begin
                o_core_ctl[c]   <= fsm_ctl[c];
                o_core_state[c] <= fsm_state[c];
            end
        end
    end

    // Shared cache flushed one way at a time once every core requests C7
    // Limitation: a cut flush is not resumed, so a short wake costs a full
    // pass over every way
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            way_q       <= '0;
            llc_flush_q <= 1'b0;
            llc_empty_q <= 1'b0;
        end else if (!all_c7) begin
            // Any wake abandons the flush; the next flush restarts from way zero
            way_q       <= '0;
            llc_flush_q <= 1'b0;
            llc_empty_q <= 1'b0;
        end else if (!llc_empty_q) begin
            llc_flush_q <= 1'b1;
            if (llc_flush_q && i_way_flushed) begin
                if (way_q == WW'(LLC_WAYS - 1)) begin
                    llc_empty_q <= 1'b1;
                    llc_flush_q <= 1'b0;
                end else begin
                    way_q <= way_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_llc_flush        <= 1'b0;
            o_llc_way          <= '0;
            o_llc_power_off    <= 1'b0;
            o_system_agent_off <= 1'b0;
        end else begin
            o_llc_flush        <= llc_flush_q;
            o_llc_way          <= way_q;
            o_llc_power_off    <= llc_empty_q;
            o_system_agent_off <= llc_empty_q;
        end
    end

    // Memory power mode and DRAM clock enable
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_mem_mode <= psc_pkg::PSC_MEM_UP;
            o_dram_cke <= 1'b1;
        end else begin
            unique case (i_mem_req)
                psc_pkg::PSC_MEM_UP: begin
                    o_mem_mode <= psc_pkg::PSC_MEM_UP;
                    o_dram_cke <= 1'b1;
                end
                psc_pkg::PSC_MEM_PRECHARGE_PD,
                psc_pkg::PSC_MEM_ACTIVE_PD: begin
                    // Bank status picks the power-down flavour; trusting
                    // the request could power down with a row still open
                    o_mem_mode <= i_banks_open
                        ? psc_pkg::PSC_MEM_ACTIVE_PD
                        : psc_pkg::PSC_MEM_PRECHARGE_PD;
                    o_dram_cke <= 1'b0;
                end
                psc_pkg::PSC_MEM_SELF_REFRESH: begin
                    o_mem_mode <= psc_pkg::PSC_MEM_SELF_REFRESH;
                    o_dram_cke <= 1'b0;
                end
            endcase
        end
    end

    // Sleep decode shared by the link, graphics and package logic
    assign in_s0      = (i_sys_state == psc_pkg::PSC_SYS_S0);
    assign gfx_asleep = i_gfx_d3 && !in_s0;

    // Links follow requests; forced off while the package is off
    // Picking a state by exit latency is left to the requester
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pcie_state         <= psc_pkg::PSC_LINK_L0;
            o_chipset_link_state <= psc_pkg::PSC_LINK_L0;
        end else if (!in_s0) begin
            o_pcie_state         <= psc_pkg::PSC_LINK_L3;
            o_chipset_link_state <= psc_pkg::PSC_LINK_L3;
        end else begin
            o_pcie_state         <= i_pcie_req;
            o_chipset_link_state <= i_chipset_link_req;
        end
    end

    // Graphics, package and real-time clock domain
    // D3 in S0 only blanks the display; D3 outside S0 also removes graphics power
    // The real-time clock stays up in every sleep state but mechanical off
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_display_on       <= 1'b1;
            o_gfx_power_on     <= 1'b1;
            o_package_power_on <= 1'b1;
            o_rtc_clock_on     <= 1'b1;
        end else begin
            o_display_on       <= !i_gfx_d3 && in_s0;
            o_gfx_power_on     <= !gfx_asleep;
            o_package_power_on <= in_s0;
            o_rtc_clock_on     <= i_sys_state != psc_pkg::PSC_SYS_G3;
        end
    end
endmodule

/* File: verif/psc_asserts.sv */
`timescale 1ns/100ps
module psc_asserts #(
    parameter int NUM_CORES = 2
) (
    input wire logic                   i_clk,
    input wire logic                   i_rst_n,
    input wire psc_pkg::psc_mem_mode_t i_mem_req,
    input wire logic                   i_banks_open,
    input wire psc_pkg::psc_link_t     i_pcie_req,
    input wire psc_pkg::psc_sys_t      i_sys_state,
    input wire logic                   i_gfx_d3,
    input wire psc_pkg::psc_core_ctl_t o_core_ctl [NUM_CORES],
    input wire logic                   o_dram_cke,
    input wire psc_pkg::psc_mem_mode_t o_mem_mode,
    input wire psc_pkg::psc_link_t     o_pcie_state,
    input wire psc_pkg::psc_link_t     o_chipset_link_state,
    input wire logic                   o_display_on,
    input wire logic                   o_gfx_power_on,
    input wire logic                   o_package_power_on,
    input wire logic                   o_rtc_clock_on
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    cke_up_a: assert property (
        o_mem_mode == psc_pkg::PSC_MEM_UP |-> o_dram_cke)
        else $error("clock enable low while memory up");
    cke_down_a: assert property (
        o_mem_mode != psc_pkg::PSC_MEM_UP |-> !o_dram_cke)
        else $error("clock enable high in a low-power mode");
    open_bank_a: assert property (
        i_mem_req == psc_pkg::PSC_MEM_PRECHARGE_PD && i_banks_open
        |=> o_mem_mode == psc_pkg::PSC_MEM_ACTIVE_PD)
        else $error("open bank not sent to active power-down");
    closed_bank_a: assert property (
        o_mem_mode == psc_pkg::PSC_MEM_PRECHARGE_PD |-> !$past(i_banks_open))
        else $error("precharge power-down with a bank open");
    link_follow_a: assert property (
        i_sys_state == psc_pkg::PSC_SYS_S0
        |=> o_pcie_state == $past(i_pcie_req))
        else $error("link state does not follow request");
    link_sleep_a: assert property (
        i_sys_state != psc_pkg::PSC_SYS_S0 |=> o_pcie_state ==
        psc_pkg::PSC_LINK_L3 && o_chipset_link_state == psc_pkg::PSC_LINK_L3)
        else $error("links not off in sleep");
    display_off_a: assert property (
        i_gfx_d3 || i_sys_state != psc_pkg::PSC_SYS_S0 |=> !o_display_on)
        else $error("display driven while graphics asleep");
    gfx_off_a: assert property (
        i_gfx_d3 && i_sys_state == psc_pkg::PSC_SYS_S3 |=> !o_gfx_power_on)
        else $error("graphics powered in suspend to memory");
    pkg_off_a: assert property (
        i_sys_state != psc_pkg::PSC_SYS_S0 |=> !o_package_power_on &&
        o_rtc_clock_on == ($past(i_sys_state) != psc_pkg::PSC_SYS_G3))
        else $error("package or rtc power wrong in sleep");
    save_first_a: assert property (
        $rose(o_core_ctl[0].voltage_off) |-> $past(o_core_ctl[0].state_save))
        else $error("voltage removed before state save");
endmodule

/* File: verif/psc_partner.sv */
`timescale 1ns/100ps
// Acknowledges flush and save two cycles late, and a way every other
// cycle, so the coordinator is seen waiting on each
module psc_partner #(
    parameter int NUM_CORES = 2
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    input  wire psc_pkg::psc_core_ctl_t i_ctl [NUM_CORES],
    input  wire logic                   i_llc_flush,
    output logic [NUM_CORES-1:0]        o_flush_done,
    output logic [NUM_CORES-1:0]        o_save_done,
    output logic                        o_way_flushed
);
    logic [NUM_CORES-1:0] fl_q, sv_q;
    // Done drops with the request, so a stale level never acks a re-entry
    always_ff @(posedge i_clk) begin
        for (int c = 0; c < NUM_CORES; c++) begin
            fl_q[c]         <= i_rst_n && i_ctl[c].cache_flush;
            sv_q[c]         <= i_rst_n && i_ctl[c].state_save;
            o_flush_done[c] <= fl_q[c] && i_ctl[c].cache_flush;
            o_save_done[c]  <= sv_q[c] && i_ctl[c].state_save;
        end
    end
    always_ff @(posedge i_clk) begin
        o_way_flushed <= i_rst_n && i_llc_flush && !o_way_flushed;
    end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    typedef logic [55:0] psc_row_t;
    logic                   i_clk = 1'b0;
    logic                   i_rst_n = 1'b0;
    psc_pkg::psc_cstate_t   i_thread_req [2][2];
    logic [1:0]             i_flush_done, i_save_done;
    logic                   i_way_flushed, i_banks_open, i_gfx_d3;
    psc_pkg::psc_mem_mode_t i_mem_req, o_mem_mode;
    psc_pkg::psc_link_t     i_pcie_req, i_chipset_link_req;
    psc_pkg::psc_link_t     o_pcie_state, o_chipset_link_state;
    psc_pkg::psc_sys_t      i_sys_state;
    psc_pkg::psc_core_ctl_t o_core_ctl [2];
    psc_pkg::psc_cstate_t   o_core_state [2];
    logic                   o_llc_flush, o_llc_power_off, o_system_agent_off;
    logic [1:0]             o_llc_way;
    logic                   o_dram_cke, o_display_on, o_gfx_power_on;
    logic                   o_package_power_on, o_rtc_clock_on;
    int                     failures = 0, total_checks = 0, cyc = 0;
    // Nibbles: mem, banks, pcie, chipset, sys, d3 | cke, mode, pcie,
    // chipset, display, gfx, package, rtc
    psc_row_t rows [8] = '{56'h000200_10021111, 56'h101100_01111111,
        56'h112301_02230111, 56'h203000_01301111, 56'h310011_03330001,
        56'h002221_10330001, 56'h000030_10330101, 56'h000040_10330100};

    always #12.5 i_clk = ~i_clk;

    psc_coordinator #(.NUM_CORES(2), .NUM_THREADS(2), .LLC_WAYS(4)) u_dut (
        .i_clk, .i_rst_n, .i_thread_req, .i_flush_done, .i_save_done,
        .i_way_flushed, .i_mem_req, .i_banks_open, .i_pcie_req,
        .i_chipset_link_req, .i_sys_state, .i_gfx_d3, .o_core_ctl,
        .o_core_state, .o_llc_flush, .o_llc_way, .o_llc_power_off,
        .o_system_agent_off, .o_dram_cke, .o_mem_mode, .o_pcie_state,
        .o_chipset_link_state, .o_display_on, .o_gfx_power_on,
        .o_package_power_on, .o_rtc_clock_on);
    psc_partner #(.NUM_CORES(2)) u_far (
        .i_clk, .i_rst_n, .i_ctl(o_core_ctl), .i_llc_flush(o_llc_flush),
        .o_flush_done(i_flush_done), .o_save_done(i_save_done),
        .o_way_flushed(i_way_flushed));

    task automatic chk(input string n, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One nibble per thread, core 0 first, value is the level's code
    task automatic req(input logic [15:0] v);
        foreach (i_thread_req[a, b]) begin
            i_thread_req[a][b] = psc_pkg::psc_cstate_t'(v[14-4*(2*a+b) -: 3]);
        end
    endtask
    task automatic wait_st(input int c, input psc_pkg::psc_cstate_t s);
        int n;
        n = 0;
        while (o_core_state[c] !== s && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        chk("core_state", s, o_core_state[c]);
        @(negedge i_clk);
    endtask
    // The level shows at entry; idle actions follow flush or save
    task automatic wait_gated(input int c);
        int n;
        n = 0;
        while (o_core_ctl[c].clock_gated !== 1'b1 && n < 50) begin
            @(negedge i_clk);
            n++;
        end
    endtask

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        psc_row_t    r;
        int          n;
        int          f;
        logic [31:0] got;
        req(16'h0000);
        i_mem_req = psc_pkg::PSC_MEM_UP;
        i_banks_open = 1'b0;
        i_pcie_req = psc_pkg::PSC_LINK_L0;
        i_chipset_link_req = psc_pkg::PSC_LINK_L0;
        i_sys_state = psc_pkg::PSC_SYS_S0;
        i_gfx_d3 = 1'b0;
        repeat (3) @(negedge i_clk);
        i_rst_n = 1'b1;
        chk("cke", 1, o_dram_cke);
        chk("executing", 1, o_core_ctl[0].executing);
        chk("llc_flush", 0, o_llc_flush);
        $display("reset test done");
        foreach (rows[i]) begin
            r = rows[i];
            @(negedge i_clk);
            i_mem_req = psc_pkg::psc_mem_mode_t'(r[53:52]);
            i_banks_open = r[48];
            i_pcie_req = psc_pkg::psc_link_t'(r[45:44]);
            i_chipset_link_req = psc_pkg::psc_link_t'(r[41:40]);
            i_sys_state = psc_pkg::psc_sys_t'(r[38:36]);
            i_gfx_d3 = r[32];
            repeat (2) @(negedge i_clk);
            got = {3'h0, o_dram_cke, 2'h0, o_mem_mode, 2'h0, o_pcie_state,
                2'h0, o_chipset_link_state, 3'h0, o_display_on, 3'h0,
                o_gfx_power_on, 3'h0, o_package_power_on, 3'h0,
                o_rtc_clock_on};
            chk("row_mem", r[31:24], got[31:24]);
            chk("row_link", r[23:16], got[23:16]);
            chk("row_power", r[15:0], got[15:0]);
        end
        $display("row test done");
        i_sys_state = psc_pkg::PSC_SYS_S0;
        repeat (2) @(negedge i_clk);
        req(16'h3100);
        wait_st(0, psc_pkg::PSC_C1);
        chk("halted", 1, o_core_ctl[0].halted);
        chk("core1_exec", 1, o_core_ctl[1].executing);
        req(16'h4400);
        wait_st(0, psc_pkg::PSC_C0);
        wait_st(0, psc_pkg::PSC_C6);
        wait_gated(0);
        chk("voltage_off", 1, o_core_ctl[0].voltage_off);
        chk("state_save", 0, o_core_ctl[0].state_save);
        req(16'h2222);
        wait_st(0, psc_pkg::PSC_C1E);
        chk("min_op_point", 1, o_core_ctl[0].min_op_point);
        req(16'h3300);
        wait_st(0, psc_pkg::PSC_C3);
        wait_gated(0);
        chk("clock_gated", 1, o_core_ctl[0].clock_gated);
        chk("cache_flush", 0, o_core_ctl[0].cache_flush);
        req(16'h5555);
        n = 0;
        f = 0;
        while (o_llc_power_off !== 1'b1 && n < 400) begin
            if (o_llc_flush === 1'b1) f++;
            @(negedge i_clk);
            n++;
        end
        @(negedge i_clk);
        chk("llc_off", 1, o_llc_power_off);
        chk("llc_flushing", 1, f > 0);
        chk("llc_way", 3, o_llc_way);
        chk("agent_off", 1, o_system_agent_off);
        chk("core1_c7", psc_pkg::PSC_C7, o_core_state[1]);
        req(16'h0055);
        n = 0;
        while (o_llc_power_off !== 1'b0 && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        chk("llc_off_wake", 0, o_llc_power_off);
        $display("core test done");
        // Reset in mid-run, then the first edge after its release
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_clk);
        chk("rst_exec", 1, o_core_ctl[1].executing);
        chk("rst_volt", 0, o_core_ctl[1].voltage_off);
        chk("rst_llc_off", 0, o_llc_power_off);
        i_rst_n = 1'b1;
        @(negedge i_clk);
        chk("rel_state", psc_pkg::PSC_C0, o_core_state[1]);
        chk("rel_exec", 1, o_core_ctl[1].executing);
        chk("rel_cke", 1, o_dram_cke);
        $display("mid-run reset test done");
        tally_and_finish();
    end
endmodule

bind psc_coordinator psc_asserts #(.NUM_CORES(NUM_CORES)) u_chk (
    .i_clk, .i_rst_n, .i_mem_req, .i_banks_open, .i_pcie_req, .i_sys_state,
    .i_gfx_d3, .o_core_ctl, .o_dram_cke, .o_mem_mode, .o_pcie_state,
    .o_chipset_link_state, .o_display_on, .o_gfx_power_on,
    .o_package_power_on, .o_rtc_clock_on);
